// ==== core_clock_ratio_and_reset.sv ====
`timescale 1ns/10ps
`default_nettype none
// clock ratio straps, reset sequencing and dram power-on handling
module core_clock_ratio_and_reset
#(
	parameter int LOCK_CYCLES = core_clock_pkg::LOCK_CYC
)
(
	// clock and power-on reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// board straps and reset
	input wire logic [core_clock_pkg::RATIO_W-1:0] core_ratio_select_i,
	input wire logic rst_in_n_i,
	input wire logic por_in_n_i,
	// analogue pll interface
	input wire logic pll_lock_i,
	output logic [core_clock_pkg::MULT_W-1:0] core_mult_o,
	output logic [1:0] soc_div_o,
	output logic ratio_bad_o,
	// core interface
	input wire logic irq_i,
	output logic core_rst_o,
	output logic core_idle_o,
	// reset-complete pin
	output logic rst_out_n_o,
	output logic rst_out_oe_o,
	// on-chip dram
	output logic dram_rst_o,
	output logic dram_init_o
);
	import core_clock_pkg::*;

	localparam int CNT_W = $clog2(LOCK_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LOCK_CYCLES - 1);

	// refuse a lock time the counter cannot serve
	if (LOCK_CYCLES < 1)
	begin : g_chk
		$error("LOCK_CYCLES must be at least one");
	end

	typedef enum logic [1:0] {ST_RESET, ST_LOCK, ST_IDLE, ST_RUN} phase_t;

	typedef struct packed
	{
		phase_t phase; // reset sequence position
		logic [CNT_W-1:0] lock_cnt; // cycles of steady lock seen
		logic [RATIO_W-1:0] code; // strap value caught in reset
		logic [MULT_W-1:0] mult; // multiplier to the pll
		logic [1:0] soc_div; // system bus divider
		logic ratio_bad; // reserved code was strapped
		logic core_rst; // core held in reset
		logic idle; // core waiting for interrupt
		logic done_n; // reset-complete pin level
		logic oe; // reset-complete pin enable
		logic dram_rst; // dram held in reset
		logic dram_init; // one-cycle dram init start
	} blk_state_t;

	blk_state_t s_r;
	blk_state_t s_nxt;
	logic rst_in_s; // synchronised board reset, active low
	logic por_s; // synchronised dram power-on, active low

	// board reset is asynchronous, so never use it raw
	level_sync u_rst_sync
	(
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.async_i(rst_in_n_i),
		.sync_o(rst_in_s)
	);

	// dram power-on input is asynchronous too
	level_sync u_por_sync
	(
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.async_i(por_in_n_i),
		.sync_o(por_s)
	);

	// next-state logic for the whole block
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.dram_init = 1'b0;
		s_nxt.soc_div = SOC_DIV;
		// dram follows its own power-on input only
		s_nxt.dram_rst = !por_s;
		if (s_r.dram_rst && por_s)
		begin
			s_nxt.dram_init = 1'b1;
		end
		if (!rst_in_s)
		begin
			// known state; straps are static so sampling them is safe
			s_nxt.phase = ST_RESET;
			s_nxt.lock_cnt = '0;
			s_nxt.code = core_ratio_select_i;
			s_nxt.core_rst = 1'b1;
			s_nxt.idle = 1'b1;
			s_nxt.done_n = 1'b0;
			s_nxt.oe = 1'b0;
		end
		else
		begin
			case (s_r.phase)
				ST_RESET:
				begin
					// release: hand the multiplier to the pll
					s_nxt.mult = ratio_mult(s_r.code);
					s_nxt.ratio_bad = (s_r.code == CODE_RSVD);
					s_nxt.oe = 1'b1;
					s_nxt.lock_cnt = '0;
					s_nxt.phase = ST_LOCK;
				end
				ST_LOCK:
				begin
					// a lock drop restarts the settle count
					if (!pll_lock_i)
						s_nxt.lock_cnt = '0;
					else if (s_r.lock_cnt == CNT_LAST)
					begin
						s_nxt.done_n = 1'b1;
						s_nxt.core_rst = 1'b0;
						s_nxt.phase = ST_IDLE;
					end
					else
						s_nxt.lock_cnt = s_r.lock_cnt + 1'b1;
				end
				ST_IDLE:
				begin
					// core sleeps until the first interrupt
					if (irq_i)
					begin
						s_nxt.idle = 1'b0;
						s_nxt.phase = ST_RUN;
					end
				end
				default:
				begin
					s_nxt.phase = ST_RUN;
				end
			endcase
		end
	end

	// state register; power-on leaves everything in reset
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			s_r <= '0;
			s_r.phase <= ST_RESET;
			s_r.mult <= MULT_DEFAULT;
			s_r.soc_div <= SOC_DIV;
			s_r.core_rst <= 1'b1;
			s_r.idle <= 1'b1;
			s_r.dram_rst <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	// outputs straight from the state register
	assign core_mult_o = s_r.mult;
	assign soc_div_o = s_r.soc_div;
	assign ratio_bad_o = s_r.ratio_bad;
	assign core_rst_o = s_r.core_rst;
	assign core_idle_o = s_r.idle;
	assign rst_out_n_o = s_r.done_n;
	assign rst_out_oe_o = s_r.oe;
	assign dram_rst_o = s_r.dram_rst;
	assign dram_init_o = s_r.dram_init;

	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	sequence reset_held;
		!rst_in_n_i ##1 !rst_in_n_i;
	endsequence

	sequence dram_release;
		s_r.dram_rst && por_s;
	endsequence

	// two sync stages plus the state register: the pin low on two edges
	// shows up as core reset on the second edge after the pair
	sync_depth_a: assert property (reset_held |-> ##2 core_rst_o)
		else $error("reset input not seen after two stages");

	known_reset_a: assert property (
		!rst_in_s |=> core_rst_o && core_idle_o && s_r.phase == ST_RESET)
		else $error("reset did not force known idle state");

	float_reset_a: assert property (!rst_in_s |=> !rst_out_oe_o)
		else $error("reset-complete pin driven during reset");

	mult_map_a: assert property (
		s_r.phase == ST_LOCK |-> core_mult_o == ratio_mult(s_r.code))
		else $error("multiplier does not match strap code");

	low_codes_a: assert property (
		s_r.phase == ST_LOCK && s_r.code == CODE_X8 |-> core_mult_o == MULT_8)
		else $error("code four must multiply by eight");

	high_codes_a: assert property (
		s_r.phase == ST_LOCK && s_r.code == CODE_X12
		|-> core_mult_o == MULT_12 && !ratio_bad_o)
		else $error("code six must multiply by twelve");

	rsvd_code_a: assert property (
		s_r.phase == ST_LOCK && s_r.code == CODE_RSVD
		|-> ratio_bad_o && core_mult_o == MULT_DEFAULT)
		else $error("reserved code not flagged");

	done_lock_a: assert property (
		$rose(rst_out_n_o) |->
		$past(pll_lock_i) && $past(rst_in_s) && rst_out_oe_o)
		else $error("reset-complete rose without lock");

	done_low_a: assert property (!rst_in_s |=> !rst_out_n_o)
		else $error("reset-complete high during reset");

	idle_wait_a: assert property (
		core_idle_o && !core_rst_o && !irq_i && rst_in_s |=> core_idle_o)
		else $error("core left idle without interrupt");

	dram_init_a: assert property (
		dram_release |=> dram_init_o ##1 !dram_init_o)
		else $error("dram init pulse missing after power-on");

	soc_half_a: assert property (soc_div_o == SOC_DIV)
		else $error("system bus divider not two");
endmodule
`default_nettype wire

// ==== core_clock_pkg.sv ====
// How it works
// - core clock is strap-selected multiple of input
// - codes 000..100 give 4,5,6,7,8; 000 default
// - 101 gives 10, 110 gives 12, 111 reserved
// - reset input forces known state, core idle
// - reset-complete output shows reset sequence finished
// - dram power-on input resets and initialises dram
// - asynchronous inputs pass through on-chip synchroniser
// - reset-complete output floats while reset is active
// - core leaves reset idle until an interrupt
// - system bus runs at half core clock
`default_nettype none
package core_clock_pkg;
	// ratio straps and multiplier widths
	localparam int RATIO_W = 3;
	localparam int MULT_W = 4;
	// strap codes
	localparam logic [RATIO_W-1:0] CODE_X4 = 3'h0;
	localparam logic [RATIO_W-1:0] CODE_X5 = 3'h1;
	localparam logic [RATIO_W-1:0] CODE_X6 = 3'h2;
	localparam logic [RATIO_W-1:0] CODE_X7 = 3'h3;
	localparam logic [RATIO_W-1:0] CODE_X8 = 3'h4;
	localparam logic [RATIO_W-1:0] CODE_X10 = 3'h5;
	localparam logic [RATIO_W-1:0] CODE_X12 = 3'h6;
	localparam logic [RATIO_W-1:0] CODE_RSVD = 3'h7;
	// multipliers
	localparam logic [MULT_W-1:0] MULT_4 = 4'h4;
	localparam logic [MULT_W-1:0] MULT_5 = 4'h5;
	localparam logic [MULT_W-1:0] MULT_6 = 4'h6;
	localparam logic [MULT_W-1:0] MULT_7 = 4'h7;
	localparam logic [MULT_W-1:0] MULT_8 = 4'h8;
	localparam logic [MULT_W-1:0] MULT_10 = 4'ha;
	localparam logic [MULT_W-1:0] MULT_12 = 4'hc;
	localparam logic [MULT_W-1:0] MULT_DEFAULT = MULT_4;
	// system bus divider from the core clock
	localparam logic [1:0] SOC_DIV = 2'h2;
	// pll settle time before reset-complete may rise
	localparam int CLK_PERIOD_NS = 10;
	localparam int LOCK_TIME_NS = 1000;
	localparam int LOCK_CYC = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// strap code to multiplier; reserved code falls back to default
	function automatic logic [MULT_W-1:0] ratio_mult(
		input logic [RATIO_W-1:0] code);
		logic [MULT_W-1:0] m;
		m = MULT_DEFAULT;
		case (code)
			CODE_X4: m = MULT_4;
			CODE_X5: m = MULT_5;
			CODE_X6: m = MULT_6;
			CODE_X7: m = MULT_7;
			CODE_X8: m = MULT_8;
			CODE_X10: m = MULT_10;
			CODE_X12: m = MULT_12;
			default: m = MULT_DEFAULT;
		endcase
		return m;
	endfunction
endpackage
`default_nettype wire

// ==== level_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser for an asynchronous level
module level_sync
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// level in and out
	input wire logic async_i,
	output logic sync_o
);
	typedef struct packed
	{
		logic meta; // first stage, read only by second stage
		logic hold; // second stage
	} sync_state_t;

	sync_state_t s_r;
	sync_state_t s_nxt;

	// shift the level through two stages
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.meta = async_i;
		s_nxt.hold = s_r.meta;
	end

	// resets to zero: an asserted active-low input is the safe side
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign sync_o = s_r.hold;
endmodule
`default_nettype wire

// ==== board_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// board side: reset button, ratio straps, pll lock and the pin tie
module board_model
(
	// clock
	input wire logic clk_i,
	// requests from the bench
	input wire logic rst_req_i,
	input wire logic [core_clock_pkg::RATIO_W-1:0] code_i,
	input wire logic lock_i,
	// reset-complete pin of the device
	input wire logic rst_out_n_i,
	input wire logic rst_out_oe_i,
	// board side of the device
	output logic [core_clock_pkg::RATIO_W-1:0] strap_o,
	output logic rst_in_n_o,
	output logic por_in_n_o,
	output logic pll_lock_o
);
	logic [2:0] hold_r; // stretches a short request
	initial
	begin
		strap_o = 3'h0;
		hold_r = 3'h0;
	end
	// count on the rising edge: the bench moves its requests on the
	// falling edge, so reading them here cannot race the bench
	always @(posedge clk_i)
	begin
		if (rst_req_i)
			hold_r <= 3'h4;
		else if (hold_r != 3'h0)
			hold_r <= hold_r - 3'h1;
		// straps only move while reset is held
		if (!rst_in_n_o)
			strap_o <= code_i;
	end
	// reset pin low while asked for and four edges longer
	assign rst_in_n_o = !(rst_req_i || hold_r != 3'h0);
	// lock level follows the bench straight through
	assign pll_lock_o = lock_i;
	// pin tied to the dram input; a pulldown wins while it floats
	assign por_in_n_o = rst_out_oe_i & rst_out_n_i;
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
	import core_clock_pkg::*;
	localparam int LOCK = 4; // short lock count keeps the run brief
	logic clk = 1'b0, nrst = 1'b0, rst_req = 1'b1, lock = 1'b0;
	logic irq = 1'b0;
	logic [2:0] code = 3'h0, strap;
	logic rst_in_n, por_in_n, pll_lock, bad, crst, idle, ron, roe;
	logic drst, dinit;
	logic [3:0] mult;
	logic [1:0] div;
	logic [3:0] mults [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc,
		4'h4};
	int failures = 0;
	int comparisons = 0;
	always #5 clk = ~clk;
	core_clock_ratio_and_reset #(.LOCK_CYCLES(LOCK))
		core_clock_ratio_and_reset_i (.clk_i(clk), .nrst_i(nrst),
		.core_ratio_select_i(strap), .rst_in_n_i(rst_in_n),
		.por_in_n_i(por_in_n), .pll_lock_i(pll_lock), .core_mult_o(mult),
		.soc_div_o(div), .ratio_bad_o(bad), .irq_i(irq),
		.core_rst_o(crst), .core_idle_o(idle), .rst_out_n_o(ron),
		.rst_out_oe_o(roe), .dram_rst_o(drst), .dram_init_o(dinit));
	board_model board_model_i (.clk_i(clk), .rst_req_i(rst_req),
		.code_i(code), .lock_i(lock), .rst_out_n_i(ron),
		.rst_out_oe_i(roe), .strap_o(strap), .rst_in_n_o(rst_in_n),
		.por_in_n_o(por_in_n), .pll_lock_o(pll_lock));
	// compare and count
	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cycles(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic give_verdict;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// board reset with a strap code, lock, dram start and wake-up
	task automatic boot(input logic [2:0] c, input logic [3:0] m,
		input bit drop);
		int i;
		code = c;
		rst_req = 1'b1;
		irq = 1'b1; // must be ignored outside idle
		cycles(8);
		check(4'(roe), 4'h0);
		check(4'(ron), 4'h0);
		check(4'(crst), 4'h1);
		check(4'(drst), 4'h1);
		rst_req = 1'b0;
		irq = 1'b0;
		for (i = 0; i < 12 && roe !== 1'b1; i++) cycles(1);
		check(mult, m);
		check(4'(bad), 4'(c == 3'h7));
		check(4'(div), 4'h2);
		lock = 1'b1;
		if (drop)
		begin
			// a lock drop restarts the count
			cycles(LOCK - 1);
			lock = 1'b0;
			cycles(1);
			lock = 1'b1;
		end
		cycles(LOCK - 1);
		check(4'(ron), 4'h0);
		for (i = 0; i < 4 && ron !== 1'b1; i++) cycles(1);
		check(4'(ron), 4'h1);
		check(4'(crst), 4'h0);
		check(4'(idle), 4'h1);
		for (i = 0; i < 6 && dinit !== 1'b1; i++) cycles(1);
		check(4'(dinit), 4'h1);
		check(4'(drst), 4'h0);
		cycles(1);
		check(4'(dinit), 4'h0);
		irq = 1'b1;
		cycles(1);
		irq = 1'b0;
		check(4'(idle), 4'h0);
		$display("boot with code %0d done", c);
	endtask
	initial
	begin
		cycles(20);
		check(mult, 4'h4);
		check(4'(div), 4'h2);
		check(4'(crst), 4'h1);
		check(4'(idle), 4'h1);
		check(4'(roe), 4'h0);
		check(4'(dinit), 4'h0);
		$display("power-on reset test done");
		nrst = 1'b1;
		boot(3'h0, 4'h4, 1'b1);
		for (int c = 0; c < 8; c++) boot(3'(c), mults[c], 1'b0);
		give_verdict;
	end
	// cut a hang short
	initial
	begin
		#50000;
		failures++;
		give_verdict;
	end
endmodule
`default_nettype wire
